//--- common/bitbr_regs.svh
// Register offsets, reset values, field positions and opcodes of the
// bit logic and conditional branch execution block.
// Assumes inclusion by bare name from the design files.
`ifndef BITBR_REGS_SVH
`define BITBR_REGS_SVH

// Register byte offsets on the plain register port
`define BB_ADDR_FLAGS 4'h0
`define BB_ADDR_PC 4'h4
`define BB_ADDR_RESULT 4'h8
`define BB_ADDR_STATUS 4'hC

// Reset values
`define BB_RST_FLAGS 4'h0
`define BB_RST_PC 16'h0000
`define BB_RST_RESULT 16'h0000

// Condition flag positions in the flags register
`define BB_FLAG_N 3
`define BB_FLAG_Z 2
`define BB_FLAG_V 1
`define BB_FLAG_C 0

// Status register bit positions
`define BB_STAT_TAKEN 0
`define BB_STAT_ILLEGAL 1

// Instruction fields
`define BB_BYTE_BIT 15
`define BB_OPC_HI 14
`define BB_OPC_LO 12
`define BB_BR_HI 15
`define BB_BR_LO 8
`define BB_OFS_SIGN 7
`define BB_BYTE_MSB 7

// Double operand opcodes, bits 14..12
`define BB_OPC_BIT 3'h3
`define BB_OPC_BIC 3'h4
`define BB_OPC_BIS 3'h5

// Branch opcodes, bits 15..8
`define BB_BR_HIGHER_OR_SAME 8'h86
`define BB_BR_LOWER 8'h87
`define BB_BR_LESS_OR_EQUAL 8'h07

`endif

//--- common/bitbr_pkg.sv
// Types shared by the bit logic and branch execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package bitbr_pkg;

  // Bitwise operation selected by the decoder
  typedef enum logic [1:0] {
    OP_NONE,
    OP_CLEAR,
    OP_SET,
    OP_TEST
  } logic_op_t;

  // Condition flags, in flags register order
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_t;

endpackage

//--- common/logic_if.sv
// Carrier between the decoder core and the bitwise unit.
// Assumes bitbr_pkg is compiled first.
`timescale 1ns/1ps
interface logic_if #(parameter int WIDTH = 16);
  bitbr_pkg::logic_op_t op;
  logic byte_mode;
  logic [WIDTH-1:0] src;
  logic [WIDTH-1:0] dst;
  bitbr_pkg::flags_t flags_in;
  logic [WIDTH-1:0] result;
  bitbr_pkg::flags_t flags_out;
  logic write;

  modport unit (input op, byte_mode, src, dst, flags_in, output result, flags_out, write);
  modport core (output op, byte_mode, src, dst, flags_in, input result, flags_out, write);
endinterface

//--- src/bit_logic_unit.sv
// Combinational bitwise unit: clear, set and test with flag update.
// Assumes the core holds operands and flags steady while it samples.
`timescale 1ns/1ps
`include "bitbr_regs.svh"
module bit_logic_unit #(
  parameter int WIDTH = 16
) (
  // Operation and operands
  logic_if.unit lif
);

  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] merged;
  logic top_bit;
  logic is_zero;

  // Operation result and flag update
  always_comb begin
    raw = '0;
    unique case (lif.op)
      bitbr_pkg::OP_CLEAR: raw = lif.dst & ~lif.src; // RQ4
      bitbr_pkg::OP_SET: raw = lif.dst | lif.src; // RQ5
      bitbr_pkg::OP_TEST: raw = lif.dst & lif.src; // RQ6
      bitbr_pkg::OP_NONE: raw = lif.dst;
    endcase
    // Byte forms touch only the low byte
    if (lif.byte_mode) begin
      merged = {lif.dst[WIDTH-1:`BB_BYTE_MSB+1], raw[`BB_BYTE_MSB:0]};
      top_bit = raw[`BB_BYTE_MSB];
      is_zero = (raw[`BB_BYTE_MSB:0] == 8'h00);
    end else begin
      merged = raw;
      top_bit = raw[WIDTH-1];
      is_zero = (raw == '0);
    end
    lif.result = merged;
    lif.write = (lif.op == bitbr_pkg::OP_CLEAR) || (lif.op == bitbr_pkg::OP_SET); // RQ6
    lif.flags_out = lif.flags_in;
    if (lif.op != bitbr_pkg::OP_NONE) begin
      lif.flags_out.n = top_bit; // RQ7
      lif.flags_out.z = is_zero; // RQ7
      lif.flags_out.v = 1'b0; // RQ7
    end
  end

endmodule

//--- src/bitbr_exec.sv
// Execution core for bit clear, bit set, bit test and three
// conditional branches, with flags and program counter registers.
// Assumes operands are fetched elsewhere and presented with exec_valid.
//
// Summary of operation
// RQ1 - Higher-or-same branches when carry is clear
// RQ2 - Lower branches on carry set, flags kept
// RQ3 - Less-or-equal branches on Z or N!=V
// RQ4 - Clear writes destination AND NOT source
// RQ5 - Set writes source OR destination
// RQ6 - Test only updates flags, writes nothing
// RQ7 - Logic ops: N=msb, Z=zero, V=0, C kept
// RQ8 - Offset sign-extended, doubled, added to PC
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bitbr_regs.svh"
module bitbr_exec #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction execution request
  input wire logic exec_valid,
  input wire logic [15:0] instr,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic [WIDTH-1:0] dst_data,
  // Execution answer
  output logic exec_done,
  output logic [WIDTH-1:0] result_data,
  output logic result_write,
  output logic branch_taken,
  output logic illegal_instr,
  output logic [WIDTH-1:0] pc_value,
  output logic [3:0] flags_value,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);

  logic_if #(.WIDTH(WIDTH)) lif ();

  bit_logic_unit #(.WIDTH(WIDTH)) u_unit (
    .lif(lif.unit)
  );

  // Architectural state
  bitbr_pkg::flags_t flags;
  bitbr_pkg::flags_t next_flags;
  logic [WIDTH-1:0] pc;
  logic [WIDTH-1:0] next_pc;
  logic [WIDTH-1:0] result;
  logic [WIDTH-1:0] next_result;
  logic taken;
  logic next_taken;
  logic illegal;
  logic next_illegal;
  logic done;
  logic next_done;
  logic wr_pulse;
  logic next_wr_pulse;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Decode
  logic [7:0] br_code;
  logic [2:0] dop_code;
  logic is_hs;
  logic is_lo;
  logic is_le;
  logic is_branch;
  logic cond;
  logic [WIDTH-1:0] offset;
  logic [WIDTH-1:0] target;

  // Branch and double operand decode
  always_comb begin
    br_code = instr[`BB_BR_HI:`BB_BR_LO];
    dop_code = instr[`BB_OPC_HI:`BB_OPC_LO];
    is_hs = (br_code == `BB_BR_HIGHER_OR_SAME);
    is_lo = (br_code == `BB_BR_LOWER);
    is_le = (br_code == `BB_BR_LESS_OR_EQUAL);
    is_branch = is_hs | is_lo | is_le;
    // Branch codes win; their top bit is not a byte-form flag
    lif.op = bitbr_pkg::OP_NONE;
    if (!is_branch) begin
      unique case (dop_code)
        `BB_OPC_BIC: lif.op = bitbr_pkg::OP_CLEAR;
        `BB_OPC_BIS: lif.op = bitbr_pkg::OP_SET;
        `BB_OPC_BIT: lif.op = bitbr_pkg::OP_TEST;
        default: lif.op = bitbr_pkg::OP_NONE;
      endcase
    end
    lif.byte_mode = instr[`BB_BYTE_BIT];
    lif.src = src_data;
    lif.dst = dst_data;
    lif.flags_in = flags;
  end

  // Branch condition and target
  // Flags as held before any same-cycle software write
  always_comb begin
    cond = 1'b0;
    if (is_hs) begin
      cond = ~flags.c; // RQ1
    end else if (is_lo) begin
      cond = flags.c; // RQ2
    end else if (is_le) begin
      cond = flags.z | (flags.n ^ flags.v); // RQ3
    end
    // Low byte sign-extended and doubled
    offset = {{(WIDTH-`BB_OFS_SIGN-2){instr[`BB_OFS_SIGN]}}, instr[`BB_OFS_SIGN:0], 1'b0}; // RQ8
    target = pc + offset; // RQ8
  end

  // Next state of execution and registers
  always_comb begin
    next_flags = flags;
    next_pc = pc;
    next_result = result;
    next_taken = 1'b0;
    next_illegal = 1'b0;
    next_done = 1'b0;
    next_wr_pulse = 1'b0;
    // Software writes first, execution overrides
    // Result and status stay read-only to software
    if (reg_write) begin
      unique case (reg_addr)
        `BB_ADDR_FLAGS: next_flags = bitbr_pkg::flags_t'(reg_wdata[3:0]);
        `BB_ADDR_PC: next_pc = reg_wdata[WIDTH-1:0];
        default: next_flags = flags;
      endcase
    end
    if (exec_valid) begin
      next_done = 1'b1;
      if (is_branch) begin
        // Flags untouched by every branch
        next_flags = flags; // RQ2 RQ3
        next_taken = cond;
        if (cond) begin
          next_pc = target; // RQ1 RQ2 RQ3
        end
      end else if (lif.op != bitbr_pkg::OP_NONE) begin
        next_flags = lif.flags_out; // RQ7
        next_wr_pulse = lif.write; // RQ6
        if (lif.write) begin
          next_result = lif.result; // RQ4 RQ5
        end
      end else begin
        next_illegal = 1'b1;
      end
    end
  end

  // Read data mux, valid the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      unique case (reg_addr)
        `BB_ADDR_FLAGS: next_rdata = {28'h000_0000, flags};
        `BB_ADDR_PC: next_rdata = 32'(pc);
        `BB_ADDR_RESULT: next_rdata = 32'(result);
        // Status only mirrors the one-cycle answer pulses
        `BB_ADDR_STATUS: begin
          next_rdata[`BB_STAT_TAKEN] = taken;
          next_rdata[`BB_STAT_ILLEGAL] = illegal;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Flags, program counter and result word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags <= bitbr_pkg::flags_t'(`BB_RST_FLAGS);
      pc <= `BB_RST_PC;
      result <= `BB_RST_RESULT;
    end else begin
      flags <= next_flags;
      pc <= next_pc;
      result <= next_result;
    end
  end

  // Answer pulses, cleared again unless a new instruction runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      taken <= 1'b0;
      illegal <= 1'b0;
      done <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      taken <= next_taken;
      illegal <= next_illegal;
      done <= next_done;
      wr_pulse <= next_wr_pulse;
    end
  end

  // Read data, zero outside the cycle after a read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Outputs straight from registers
  assign exec_done = done;
  assign result_data = result;
  assign result_write = wr_pulse;
  assign branch_taken = taken;
  assign illegal_instr = illegal;
  assign pc_value = pc;
  assign flags_value = flags;
  assign reg_rdata = rdata;

endmodule

//--- tb/bitbr_exec_checker.sv
// Checker: concurrent properties on the execution core ports.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module bitbr_exec_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Execution port
  input wire logic exec_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] src_data,
  input wire logic [15:0] dst_data,
  input wire logic exec_done,
  input wire logic [15:0] result_data,
  input wire logic result_write,
  input wire logic branch_taken,
  input wire logic [15:0] pc_value,
  input wire logic [3:0] flags_value,
  // Register port
  input wire logic reg_write
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Doubled signed offset and logic-op decode
  wire [15:0] ofs = {{7{instr[7]}}, instr[7:0], 1'b0};
  wire [7:0] br = instr[15:8];
  wire is_br = br == 8'h86 || br == 8'h87 || br == 8'h07;
  wire lop = exec_valid && !is_br && instr[14:12] >= 3'h3 && instr[14:12] <= 3'h5;
  AST_DONE: assert property (exec_valid |=> exec_done) else $error("done missing");
  AST_CLEAR: assert property (lop && instr[15:12] == 4'h4 |=> result_write &&
    result_data == ($past(dst_data) & ~$past(src_data))) else $error("clear wrong");
  AST_SET: assert property (lop && instr[15:12] == 4'h5 |=> result_write &&
    result_data == ($past(dst_data) | $past(src_data))) else $error("set wrong");
  AST_TEST: assert property (lop && instr[14:12] == 3'h3 |=>
    !result_write && $stable(result_data)) else $error("test wrote");
  AST_FLAGS: assert property (lop && !reg_write |=> !flags_value[1] &&
    flags_value[0] == $past(flags_value[0])) else $error("logic flags wrong");
  AST_HIGHER: assert property (exec_valid && !reg_write && br == 8'h86 |=>
    branch_taken != $past(flags_value[0]) &&
    pc_value == $past(pc_value) + ($past(flags_value[0]) ? 16'h0000 : $past(ofs)))
    else $error("higher-or-same wrong");
  AST_LOWER_PC: assert property (exec_valid && !reg_write && br == 8'h87 |=>
    pc_value == $past(pc_value) + ($past(flags_value[0]) ? $past(ofs) : 16'h0000))
    else $error("lower target wrong");
  AST_LOWER: assert property (exec_valid && br == 8'h87 |=>
    branch_taken == $past(flags_value[0]) && flags_value == $past(flags_value))
    else $error("lower wrong");
  AST_LESS: assert property (exec_valid && !reg_write && br == 8'h07 |=>
    branch_taken == ($past(flags_value[2]) || $past(flags_value[3]) != $past(flags_value[1]))
    && flags_value == $past(flags_value)) else $error("less-or-equal wrong");
endmodule

bind bitbr_exec bitbr_exec_checker bitbr_exec_checker_inst (.core_clk, .rst, .exec_valid,
  .instr, .src_data, .dst_data, .exec_done, .result_data, .result_write, .branch_taken,
  .pc_value, .flags_value, .reg_write);

//--- tb/bit_logic_and_cond_branch_tb.sv
// Testbench: drives the execution and register ports by table.
// Assumes the design and checker files are compiled before it.
`timescale 1ns/1ps
module bit_logic_and_cond_branch_tb;
  logic core_clk = 0, rst = 1, exec_valid = 0, reg_write = 0, reg_read = 0;
  logic [15:0] instr = 16'h0000, src_data = 16'h0000, dst_data = 16'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic exec_done, result_write, branch_taken, illegal_instr;
  logic [15:0] result_data, pc_value;
  logic [3:0] flags_value;
  logic [31:0] reg_rdata;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  // Logic ops: instr, src, dst, result, flags
  logic [15:0] lt [6][5] = '{'{16'h4000, 16'h00F0, 16'h80FF, 16'h800F, 16'h9},
    '{16'hC000, 16'h00FF, 16'hAB0F, 16'hAB00, 16'h5},
    '{16'h5000, 16'h0001, 16'h0000, 16'h0001, 16'h1},
    '{16'hD000, 16'h0080, 16'h1200, 16'h1280, 16'h9},
    '{16'h3000, 16'h00FF, 16'hFF00, 16'h1280, 16'h5},
    '{16'hB000, 16'h0080, 16'h0081, 16'h1280, 16'h9}};
  // Branches: flags, instr, taken, pc
  logic [15:0] bt [7][4] = '{'{16'h1, 16'h8605, 16'h0, 16'h0100},
    '{16'h1, 16'h87FF, 16'h1, 16'h00FE}, '{16'h8, 16'h0702, 16'h1, 16'h0102},
    '{16'hA, 16'h0780, 16'h0, 16'h0102}, '{16'h0, 16'h8680, 16'h1, 16'h0002},
    '{16'h0, 16'h8701, 16'h0, 16'h0002}, '{16'h4, 16'h0701, 16'h1, 16'h0004}};

  bitbr_exec bitbr_exec_inst (.core_clk, .rst, .exec_valid, .instr, .src_data, .dst_data,
    .exec_done, .result_data, .result_write, .branch_taken, .illegal_instr, .pc_value,
    .flags_value, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);

  // 25 MHz clock
  initial forever #20 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask

  task automatic ex(input logic [15:0] i, s, d);
    @(posedge core_clk);
    exec_valid <= 1'b1; instr <= i; src_data <= s; dst_data <= d;
    @(posedge core_clk);
    exec_valid <= 1'b0;
    #1 chk("done", exec_done, 1);
  endtask

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cycle ceiling against hangs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      conclude;
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("reset pc", pc_value, 0);
    chk("reset flags", flags_value, 0);
    wr(4'h0, 32'h1);
    foreach (lt[k]) begin
      ex(lt[k][0], lt[k][1], lt[k][2]);
      chk("write", result_write, lt[k][0][14:12] != 3'h3);
      chk("result", result_data, lt[k][3]);
      chk("flags", flags_value, lt[k][4]);
    end
    $display("logic ops done");
    wr(4'h4, 32'h0100);
    foreach (bt[k]) begin
      wr(4'h0, bt[k][0]);
      ex(bt[k][1], 16'h0000, 16'h0000);
      chk("taken", branch_taken, bt[k][2]);
      chk("pc", pc_value, bt[k][3]);
      chk("flags", flags_value, bt[k][0]);
    end
    $display("branches done");
    ex(16'h1000, 16'h0000, 16'h0000);
    chk("illegal", illegal_instr, 1);
    rd(4'h4, 32'h0004);
    rd(4'h2, 32'h0);
    rd(4'h0, 32'h4);
    rd(4'h8, 32'h1280);
    // Status is read in the cycle in which the answer pulses stand
    fork
      ex(16'h0701, 16'h0000, 16'h0000);
      begin
        @(posedge core_clk);
        rd(4'hC, 32'h1);
      end
    join
    fork
      begin
        ex(16'h1000, 16'h0000, 16'h0000);
        chk("illegal", illegal_instr, 1);
      end
      begin
        @(posedge core_clk);
        rd(4'hC, 32'h2);
      end
    join
    chk("pc", pc_value, 16'h0006);
    $display("registers done");
    conclude;
  end
endmodule
